// ===== ppt_pkg.sv
// ppt_pkg: constants and carrier types for the prescaled periodic timer block
// assumes a processor core on sys_clk that issues one-cycle op strobes with its accumulator
package ppt_pkg;
	localparam int INSTR_DIV = 3;
	localparam logic [1:0] INSTR_LAST = 2'h2;
	localparam int CNT_W = 8;
	localparam int NIB_W = 4;
	localparam int TW2_START_BIT = 2;
	localparam int TW3_AUTOSTOP_BIT = 3;
	localparam int TW3_START_BIT = 2;
	localparam int PSC_RUN_BIT = 0;
	localparam int IRQ1_T2_EN_BIT = 3;
	localparam int IRQ2_T3_EN_BIT = 0;
	localparam logic [1:0] SRC_INSTR = 2'h0;
	localparam logic [1:0] SRC_PRESCALER = 2'h1;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [7:0] RELOAD_RESET = 8'hff;

	typedef struct packed {
		logic load_timer_two_ctrl_op;
		logic load_timer_three_ctrl_op;
		logic load_prescaler_ctrl_op;
		logic load_irq_ctrl_one_op;
		logic load_irq_ctrl_two_op;
		logic test_clear_timer_two_flag_op;
		logic test_clear_timer_three_flag_op;
		logic irq_on_op;
		logic irq_off_op;
		logic load_timer_two_reload_op;
		logic load_timer_three_reload_op;
		logic load_prescaler_reload_op;
	} ppt_ops_t;

	typedef struct packed {
		logic irq_take_two;
		logic irq_take_three;
		logic global_enable;
		logic skip_next;
	} ppt_status_t;
endpackage

// ===== ppt_reload_counter.sv
// ppt_reload_counter: down counter that reloads on underflow
// assumes tick is a one-cycle pulse on sys_clk
`timescale 1ns/1ns
module ppt_reload_counter #(
	parameter int W = 8
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic run,
	input wire logic tick,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic [W-1:0] reload_val,
	output logic [W-1:0] count,
	output logic underflow
);
	logic [W-1:0] count_q;
	logic [W-1:0] count_d;

	// underflow when a source pulse finds zero, so the divide ratio is reload+1
	assign underflow = run & tick & (count_q == '0);
	assign count = count_q;

	// direct load wins so a stopped counter restarts from the fresh value
	always_comb
	begin
		count_d = count_q;
		if (load)
			count_d = load_val;
		else if (underflow)
			count_d = reload_val;
		else if (run & tick)
			count_d = count_q - {{(W-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			count_q <= '0;
		else
			count_q <= count_d;
	end
endmodule

// ===== ppt_timer_top.sv
// ppt_timer_top: instruction clock, shared prescaler, timers two and three, interrupt gating
// assumes the core drives ops as one-cycle strobes with acc/data valid in the same cycle
`timescale 1ns/1ns
module ppt_timer_top (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire ppt_pkg::ppt_ops_t ops,
	input wire logic [ppt_pkg::NIB_W-1:0] acc,
	input wire logic [ppt_pkg::CNT_W-1:0] data,
	input wire logic irq_accept,
	output ppt_pkg::ppt_status_t status,
	output logic [ppt_pkg::NIB_W-1:0] timer_two_control,
	output logic [ppt_pkg::NIB_W-1:0] timer_three_control,
	output logic timer_two_req_flag,
	output logic timer_three_req_flag,
	output logic prescaler_out_clock,
	output logic [ppt_pkg::CNT_W-1:0] timer_two_count,
	output logic [ppt_pkg::CNT_W-1:0] timer_three_count
);
	import ppt_pkg::*;

	// source pulse for a timer from its select field; unused codes give no pulses
	function automatic logic src_pulse(input logic [1:0] sel, input logic it, input logic po);
		src_pulse = (sel == SRC_INSTR) ? it : ((sel == SRC_PRESCALER) ? po : 1'b0);
	endfunction

	// state registers and their next values
	logic [1:0] div_q;
	logic [1:0] div_d;
	logic instr_tick;
	logic [NIB_W-1:0] tw2_q, tw2_d, tw3_q, tw3_d;
	logic [NIB_W-1:0] irq_en_one_q, irq_en_one_d, irq_en_two_q, irq_en_two_d;
	logic psc_run_q, psc_run_d;
	logic [CNT_W-1:0] reload_two_q, reload_two_d, reload_three_q, reload_three_d;
	logic [CNT_W-1:0] psc_reload_q, psc_reload_d;
	logic f2_q, f2_d, f3_q, f3_d, ie_q, ie_d, skip_q, skip_d;
	logic run2, run3, run_ps, src2, src3, uf2, uf3;
	logic take2, take3;

	// instruction clock: one tick every three system clocks
	always_comb
	begin
		div_d = (div_q == INSTR_LAST) ? 2'h0 : div_q + 2'h1;
	end
	assign instr_tick = (div_q == INSTR_LAST);

	// divider phase; reset puts the first tick on the third clock after release
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			div_q <= 2'h0;
		else
			div_q <= div_d;
	end

	// run enables and count sources; codes 10 and 11 leave a timer without pulses
	assign run_ps = psc_run_q;
	assign run2 = tw2_q[TW2_START_BIT];
	assign run3 = tw3_q[TW3_START_BIT];
	assign src2 = src_pulse(tw2_q[1:0], instr_tick, prescaler_out_clock);
	assign src3 = src_pulse(tw3_q[1:0], instr_tick, prescaler_out_clock);

	// prescaler divides the instruction tick by reload+1
	ppt_reload_counter #(.W(CNT_W)) u_prescaler (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.run(run_ps),
		.tick(instr_tick),
		.load(ops.load_prescaler_reload_op & ~run_ps),
		.load_val(data),
		.reload_val(psc_reload_q),
		.count(),
		.underflow(prescaler_out_clock)
	);

	// timer two counts the source picked by its control bits 1..0
	ppt_reload_counter #(.W(CNT_W)) u_timer_two (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.run(run2),
		.tick(src2),
		.load(ops.load_timer_two_reload_op & ~run2),
		.load_val(data),
		.reload_val(reload_two_q),
		.count(timer_two_count),
		.underflow(uf2)
	);

	// timer three likewise; its start bit may be cleared by the auto-stop path
	ppt_reload_counter #(.W(CNT_W)) u_timer_three (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.run(run3),
		.tick(src3),
		.load(ops.load_timer_three_reload_op & ~run3),
		.load_val(data),
		.reload_val(reload_three_q),
		.count(timer_three_count),
		.underflow(uf3)
	);

	// interrupt taken only with flag, own enable and global enable all set
	assign take2 = f2_q & irq_en_one_q[IRQ1_T2_EN_BIT] & ie_q;
	assign take3 = f3_q & irq_en_two_q[IRQ2_T3_EN_BIT] & ie_q;

	// control and reload registers; a reload write to a running counter only lands here
	always_comb
	begin
		tw2_d = ops.load_timer_two_ctrl_op ? acc : tw2_q;
		tw3_d = ops.load_timer_three_ctrl_op ? acc : tw3_q;
		// auto-stop: a selected one-shot clears its own start bit at underflow
		if (uf3 & tw3_q[TW3_AUTOSTOP_BIT] & ~ops.load_timer_three_ctrl_op)
			tw3_d[TW3_START_BIT] = 1'b0;
		psc_run_d = ops.load_prescaler_ctrl_op ? acc[PSC_RUN_BIT] : psc_run_q;
		irq_en_one_d = ops.load_irq_ctrl_one_op ? acc : irq_en_one_q;
		irq_en_two_d = ops.load_irq_ctrl_two_op ? acc : irq_en_two_q;
		reload_two_d = ops.load_timer_two_reload_op ? data : reload_two_q;
		reload_three_d = ops.load_timer_three_reload_op ? data : reload_three_q;
		psc_reload_d = ops.load_prescaler_reload_op ? data : psc_reload_q;
	end

	// reloads come up at all ones, so a timer started without a reload write is slowest
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tw2_q <= CTRL_RESET;
			tw3_q <= CTRL_RESET;
			irq_en_one_q <= CTRL_RESET;
			irq_en_two_q <= CTRL_RESET;
			psc_run_q <= 1'b0;
			reload_two_q <= RELOAD_RESET;
			reload_three_q <= RELOAD_RESET;
			psc_reload_q <= RELOAD_RESET;
		end
		else
		begin
			tw2_q <= tw2_d;
			tw3_q <= tw3_d;
			irq_en_one_q <= irq_en_one_d;
			irq_en_two_q <= irq_en_two_d;
			psc_run_q <= psc_run_d;
			reload_two_q <= reload_two_d;
			reload_three_q <= reload_three_d;
			psc_reload_q <= psc_reload_d;
		end
	end

	// global enable: irq_on wins a tie so a return sequence can reopen the gate at once
	always_comb
	begin
		ie_d = ie_q;
		if (ops.irq_on_op)
			ie_d = 1'b1;
		else if (ops.irq_off_op | irq_accept)
			ie_d = 1'b0;
	end

	// global enable register, closed out of reset
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			ie_q <= 1'b0;
		else
			ie_q <= ie_d;
	end

	// request flags and the skip marker for the core
	always_comb
	begin
		skip_d = skip_q;
		f2_d = f2_q;
		f3_d = f3_q;
		// test op only works while the own enable is 0; an enabled flag goes by interrupt
		if (ops.test_clear_timer_two_flag_op)
		begin
			skip_d = f2_q & ~irq_en_one_q[IRQ1_T2_EN_BIT];
			if (~irq_en_one_q[IRQ1_T2_EN_BIT])
				f2_d = 1'b0;
		end
		else if (ops.test_clear_timer_three_flag_op)
		begin
			skip_d = f3_q & ~irq_en_two_q[IRQ2_T3_EN_BIT];
			if (~irq_en_two_q[IRQ2_T3_EN_BIT])
				f3_d = 1'b0;
		end
		else
			skip_d = 1'b0;
		// accept services timer two first, then timer three
		if (irq_accept & take2)
			f2_d = 1'b0;
		else if (irq_accept & take3)
			f3_d = 1'b0;
		// a new underflow beats any clear in the same cycle
		if (uf2)
			f2_d = 1'b1;
		if (uf3)
			f3_d = 1'b1;
	end

	// flag state; skip only stands for the cycle after the test op
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			f2_q <= 1'b0;
			f3_q <= 1'b0;
			skip_q <= 1'b0;
		end
		else
		begin
			f2_q <= f2_d;
			f3_q <= f3_d;
			skip_q <= skip_d;
		end
	end

	// outputs straight from the registers, except the take lines, which gate each flag with its own and the global enable
	assign timer_two_control = tw2_q;
	assign timer_three_control = tw3_q;
	assign timer_two_req_flag = f2_q;
	assign timer_three_req_flag = f3_q;
	assign status.irq_take_two = take2;
	assign status.irq_take_three = take3;
	assign status.global_enable = ie_q;
	assign status.skip_next = skip_q;
endmodule

// ===== ppt_timer_checker.sv
// ppt_timer_checker: port-level assertions for ppt_timer_top
// assumes one-cycle op strobes and active-low async reset
`timescale 1ns/1ns
module ppt_timer_checker (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire ppt_pkg::ppt_ops_t ops,
	input wire logic [ppt_pkg::NIB_W-1:0] acc,
	input wire logic irq_accept,
	input wire ppt_pkg::ppt_status_t status,
	input wire logic [ppt_pkg::NIB_W-1:0] timer_two_control,
	input wire logic [ppt_pkg::NIB_W-1:0] timer_three_control,
	input wire logic timer_two_req_flag,
	input wire logic timer_three_req_flag,
	input wire logic prescaler_out_clock,
	input wire logic [ppt_pkg::CNT_W-1:0] timer_two_count,
	input wire logic [ppt_pkg::CNT_W-1:0] timer_three_count
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// a request line needs its flag and the global enable behind it
	take2_a: assert property (status.irq_take_two |->
		timer_two_req_flag && status.global_enable) else $error("take two without cause");
	take3_a: assert property (status.irq_take_three |->
		timer_three_req_flag && status.global_enable) else $error("take three without cause");
	gie_on_a: assert property (ops.irq_on_op |=> status.global_enable)
		else $error("global enable not set");
	gie_off_a: assert property ((ops.irq_off_op || irq_accept) && !ops.irq_on_op |=>
		!status.global_enable) else $error("global enable not cleared");
	// a stopped timer keeps its count unless a reload is written
	t2_hold_a: assert property (!timer_two_control[2] && !ops.load_timer_two_reload_op |=>
		$stable(timer_two_count)) else $error("timer two moved while stopped");
	t3_hold_a: assert property (!timer_three_control[2] && !ops.load_timer_three_reload_op |=>
		$stable(timer_three_count)) else $error("timer three moved while stopped");
	t2_ctrl_a: assert property (ops.load_timer_two_ctrl_op |=> timer_two_control == $past(acc))
		else $error("timer two control not loaded");
	t3_ctrl_a: assert property (ops.load_timer_three_ctrl_op |=> timer_three_control == $past(acc))
		else $error("timer three control not loaded");
	// the skip marker only follows a flag-test op
	skip_src_a: assert property (status.skip_next |->
		$past(ops.test_clear_timer_two_flag_op || ops.test_clear_timer_three_flag_op))
		else $error("skip without a test op");
	// ticks come every third clock, so the prescaler pulse is followed by two quiet cycles
	pres_gap_a: assert property (prescaler_out_clock |=> !prescaler_out_clock [*2])
		else $error("prescaler pulses too close");
	cover property (status.irq_take_two);
	cover property (status.skip_next);
	cover property (timer_three_req_flag && !timer_three_control[2]);
endmodule
bind ppt_timer_top ppt_timer_checker u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .ops(ops),
	.acc(acc), .irq_accept(irq_accept), .status(status), .timer_two_control(timer_two_control),
	.timer_three_control(timer_three_control), .timer_two_req_flag(timer_two_req_flag),
	.timer_three_req_flag(timer_three_req_flag), .prescaler_out_clock(prescaler_out_clock),
	.timer_two_count(timer_two_count), .timer_three_count(timer_three_count));

// ===== test_prescaled_periodic_timer_irq.sv
// test_prescaled_periodic_timer_irq: self-checking bench for ppt_timer_top
// assumes the one-strobe-per-cycle op contract of the block
`timescale 1ns/1ns
module test_prescaled_periodic_timer_irq;
	import ppt_pkg::*;
	localparam int T2C = 11, T3C = 10, PSC = 9, IC1 = 8, IC2 = 7, TC2 = 6, TC3 = 5;
	localparam int ION = 4, IOFF = 3, RL2 = 2, RL3 = 1, RLP = 0;
	typedef struct packed { logic is3; logic [3:0] v; } ppt_row_t;
	localparam ppt_row_t ROWS [7] = '{'{1'b0, 4'h3}, '{1'b0, 4'h0}, '{1'b1, 4'h0},
		'{1'b1, 4'h1}, '{1'b1, 4'h2}, '{1'b1, 4'hb}, '{1'b1, 4'h0}};
	logic sys_clk, reset_n, irq_accept, f2, f3, pclk;
	ppt_ops_t ops;
	ppt_status_t status;
	logic [NIB_W-1:0] acc, tc2, tc3;
	logic [CNT_W-1:0] data, c2, c3, saved;
	int err_count, tests_run, cyc, t0, n;
	ppt_timer_top u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .ops(ops), .acc(acc), .data(data),
		.irq_accept(irq_accept), .status(status), .timer_two_control(tc2),
		.timer_three_control(tc3), .timer_two_req_flag(f2), .timer_three_req_flag(f3),
		.prescaler_out_clock(pclk), .timer_two_count(c2), .timer_three_count(c3));
	// clock, and an edge counter used to time the periods
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) cyc <= cyc + 1;
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one strobe for one taking edge; returns just after that edge has landed
	task automatic op(input int i, input logic [3:0] a = 4'h0, input logic [7:0] d = 8'h00);
		@(posedge sys_clk);
		ops <= ppt_ops_t'(12'h001 << i);
		acc <= a;
		data <= d;
		@(posedge sys_clk);
		ops <= '0; // idle slot stands in for the no-op after a test op
		#1;
	endtask
	function automatic logic sel(input int s);
		return s == 0 ? pclk : (s == 2 ? f2 : f3);
	endfunction
	// bounded wait for 0 prescaler pulse, 2 or 3 that timer's flag; a run-out is a mismatch
	task automatic wrise(input int s);
		n = 0;
		do
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		while (!sel(s) && n < 300);
		chk("wait", 8'h01, sel(s));
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// watchdog sized well beyond the several hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		final_report;
	end
	initial
	begin
		{ops, acc, data, irq_accept, reset_n, cyc, err_count, tests_run} = '0;
		repeat (12) @(posedge sys_clk);
		chk("reset regs", 8'h00, {tc2, tc3});
		chk("reset flags", 8'h00, {f2, f3, status, pclk});
		reset_n <= 1'b1;
		foreach (ROWS[i])
		begin
			op(ROWS[i].is3 ? T3C : T2C, ROWS[i].v);
			chk("control", {4'h0, ROWS[i].v}, ROWS[i].is3 ? tc3 : tc2);
		end
		op(RLP, 4'h0, 8'h04);
		op(RL3, 4'h0, 8'h02);
		chk("loaded three", 8'h02, c3);
		op(T3C, 4'h5);
		op(PSC, 4'h1);
		wrise(0);
		t0 = cyc;
		wrise(0);
		chk("prescaler period", 8'h0f, 8'(cyc - t0));
		wrise(3);
		t0 = cyc;
		op(TC3);
		chk("skip", 8'h01, status.skip_next);
		chk("flag three", 8'h00, f3);
		wrise(3);
		chk("timer three period", 8'h2d, 8'(cyc - t0));
		op(TC3);
		op(T3C, 4'hd);
		wrise(3);
		chk("auto stop", 8'h09, tc3);
		op(IC2, 4'h1);
		chk("take three off", 8'h00, status.irq_take_three);
		op(ION);
		chk("take three", 8'h01, status.irq_take_three);
		op(TC3);
		chk("refused clear", 8'h01, {status.skip_next, f3});
		@(posedge sys_clk);
		irq_accept <= 1'b1;
		@(posedge sys_clk);
		irq_accept <= 1'b0;
		#1;
		chk("accept", 8'h00, {status.global_enable, f3});
		op(RL2, 4'h0, 8'h05);
		op(T2C, 4'h4);
		wrise(2);
		t0 = cyc;
		op(TC2);
		wrise(2);
		chk("timer two period", 8'h12, 8'(cyc - t0));
		op(IC1, 4'h8);
		op(ION);
		chk("take two", 8'h01, status.irq_take_two);
		op(IOFF);
		chk("take two off", 8'h00, status.irq_take_two);
		op(T2C, 4'h0);
		saved = c2;
		repeat (30) @(posedge sys_clk);
		#1;
		chk("hold", saved, c2);
		op(RL2, 4'h0, 8'h07);
		chk("loaded", 8'h07, c2);
		// timer two on the prescaler output: 15 cycles per pulse times 8
		op(IC1, 4'h0);
		op(TC2);
		op(T2C, 4'h5);
		wrise(2);
		t0 = cyc;
		op(TC2);
		wrise(2);
		chk("prescaled period", 8'h78, 8'(cyc - t0));
		op(PSC, 4'h0);
		repeat (20)
		begin
			@(posedge sys_clk);
			#1;
			chk("prescaler stopped", 8'h00, pclk);
		end
		// second reset in mid-run; then a timer with no reload write reloads all ones
		@(posedge sys_clk);
		reset_n <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk("mid reset regs", 8'h00, {tc2, tc3});
		chk("mid reset flags", 8'h00, {f2, f3, status, pclk});
		chk("mid reset count", 8'h00, c2);
		@(posedge sys_clk);
		reset_n <= 1'b1;
		op(T2C, 4'h4);
		wrise(2);
		chk("reload reset", 8'hff, c2);
		final_report;
	end
endmodule
